/* File: bench/core_side_model.sv */
`timescale 1ns/1ps
module core_side_model (
  input  wire logic       clk_in,
  input  wire logic       load_in,
  input  wire logic [7:0] mem_ld_in,
  input  wire logic [7:0] io_ld_in,
  input  wire logic       mem_we_in,
  input  wire logic [7:0] mem_wdata_in,
  input  wire logic       io_we_in,
  input  wire logic [7:0] io_wdata_in,
  output logic      [7:0] mem_byte_out = 8'h00,
  output logic      [7:0] io_byte_out = 8'h00
);
  // One memory byte and one IO byte; write-back lands on the edge after the op
  always @(posedge clk_in) begin
    if (load_in) begin
      mem_byte_out <= mem_ld_in;
      io_byte_out <= io_ld_in;
    end else begin
      if (mem_we_in) mem_byte_out <= mem_wdata_in;
      if (io_we_in) io_byte_out <= io_wdata_in;
    end
  end
endmodule : core_side_model

/* File: bench/logic_op_alu_props.sv */
`timescale 1ns/1ps
module logic_op_alu_props (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       op_valid_in,
  input wire logic [3:0] op_in,
  input wire logic [7:0] imm_in,
  input wire logic [7:0] mem_rdata_in,
  input wire logic [7:0] io_rdata_in,
  input wire logic       wr_in,
  input wire logic       mem_we_out,
  input wire logic [7:0] mem_wdata_out,
  input wire logic       io_we_out,
  input wire logic [7:0] io_wdata_out,
  input wire logic [7:0] work_register_out,
  input wire logic       zero_flag_out,
  input wire logic       carry_flag_out,
  input wire logic       half_borrow_bit_out,
  input wire logic       signed_wrap_bit_out
);
  logic [7:0] w;
  logic [7:0] s;
  logic [7:0] r;
  // Reference result of the op presented this cycle
  always_comb begin
    w = work_register_out;
    s = (op_in inside {4'h1, 4'h4, 4'h7}) ? imm_in : mem_rdata_in;
    if (op_in == 4'ha) s = io_rdata_in;
    case (op_in)
      4'h1, 4'h2, 4'h3: r = w & s;
      4'h4, 4'h5, 4'h6: r = w | s;
      4'hb:             r = ~w;
      4'hc:             r = ~s;
      4'hd:             r = 8'h00 - w;
      4'he:             r = 8'h00 - s;
      default:          r = w ^ s;
    endcase
  end
  ////////////////////////////////////////
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_imm_result: assert property (op_valid_in && op_in inside {4'h1, 4'h4, 4'h7}
    |=> work_register_out == $past(r)) else $error("immediate form result wrong");
  a_acc_mem: assert property (op_valid_in && op_in inside {4'h2, 4'h5, 4'h8}
    |=> work_register_out == $past(r)) else $error("memory to work result wrong");
  a_mem_dest: assert property (op_valid_in && !wr_in && op_in inside {4'h3, 4'h6, 4'h9, 4'hc, 4'he}
    |=> mem_we_out && mem_wdata_out == $past(r) && $stable(work_register_out))
    else $error("memory write-back wrong");
  a_io_dest: assert property (op_valid_in && !wr_in && op_in == 4'ha
    |=> io_we_out && io_wdata_out == $past(r) && $stable(zero_flag_out))
    else $error("io write-back wrong");
  a_compl_acc: assert property (op_valid_in && op_in inside {4'hb, 4'hd}
    |=> work_register_out == $past(r)) else $error("complement of work wrong");
  a_zero_rule: assert property (op_valid_in && op_in inside {[4'h1:4'h9], [4'hb:4'he]}
    |=> zero_flag_out == ((mem_we_out ? mem_wdata_out : work_register_out) == 8'h00))
    else $error("zero flag wrong");
  a_flags_kept: assert property (op_valid_in && op_in != 4'h0 && !wr_in
    |=> $stable({carry_flag_out, half_borrow_bit_out, signed_wrap_bit_out}))
    else $error("other flags changed");
  a_mem_quiet: assert property (op_valid_in && op_in inside {4'h1, 4'h2, 4'h4, 4'h5, 4'h7}
    |=> !mem_we_out && !io_we_out) else $error("stray write-back");
  c_zero_and: cover property (op_valid_in && op_in == 4'h2 ##1 zero_flag_out);
  c_io_xor: cover property (io_we_out);
  c_neg_mem: cover property (op_valid_in && op_in == 4'he);
endmodule : logic_op_alu_props

bind logic_op_alu logic_op_alu_props u_logic_op_alu_props (.clk_in, .rst_in, .op_valid_in,
  .op_in, .imm_in, .mem_rdata_in, .io_rdata_in, .wr_in, .mem_we_out, .mem_wdata_out,
  .io_we_out, .io_wdata_out, .work_register_out, .zero_flag_out, .carry_flag_out,
  .half_borrow_bit_out, .signed_wrap_bit_out);

/* File: bench/logic_op_alu_test.sv */
`timescale 1ns/1ps
module logic_op_alu_test;
  import logic_op_pkg::*;
  logic       clk_in = 1'b0, rst_in = 1'b1, op_valid_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic       load = 1'b0, mem_we_out, io_we_out, done_out, zero_flag_out;
  logic       carry_flag_out, half_borrow_bit_out, signed_wrap_bit_out;
  logic [3:0] op_in = 4'h0, addr_in = 4'h0;
  logic [7:0] imm_in = 8'h00, wr_data_in = 8'h00, mem_ld = 8'h00, io_ld = 8'h00;
  logic [7:0] mem_rdata_in, io_rdata_in, mem_wdata_out, io_wdata_out;
  logic [7:0] work_register_out, rd_data_out, w, m, v, i, r, d;
  int         bad_count = 0, samples_checked = 0;
  // Operands per op code: work, memory, io, immediate
  logic [31:0] tbl [1:14] = '{32'hf3_00_00_0f, 32'h0f_f0_00_00, 32'hff_3c_00_00,
    32'h00_00_00_00, 32'h50_05_00_00, 32'h00_00_00_00, 32'haa_00_00_aa, 32'h38_0f_00_00,
    32'h5a_5a_00_00, 32'h81_00_7e_00, 32'h38_00_00_00, 32'h00_ff_00_00, 32'h38_00_00_00,
    32'h00_00_00_00};

  always #20 clk_in = ~clk_in;

  logic_op_alu u_logic_op_alu (.clk_in, .rst_in, .op_valid_in, .op_in, .imm_in, .mem_rdata_in,
    .io_rdata_in, .mem_we_out, .mem_wdata_out, .io_we_out, .io_wdata_out, .done_out,
    .work_register_out, .zero_flag_out, .carry_flag_out, .half_borrow_bit_out,
    .signed_wrap_bit_out, .addr_in, .wr_data_in, .wr_in, .rd_in, .rd_data_out);
  core_side_model u_core_side_model (.clk_in, .load_in(load), .mem_ld_in(mem_ld),
    .io_ld_in(io_ld), .mem_we_in(mem_we_out), .mem_wdata_in(mem_wdata_out),
    .io_we_in(io_we_out), .io_wdata_in(io_wdata_out), .mem_byte_out(mem_rdata_in),
    .io_byte_out(io_rdata_in));
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 q = rd_data_out;
  endtask : rd

  // Far side loaded while work and flags are written back to back
  task automatic prep(input logic [7:0] wv, mv, iv);
    @(posedge clk_in);
    load <= 1'b1;
    mem_ld <= mv;
    io_ld <= iv;
    wr_in <= 1'b1;
    addr_in <= REG_WORK;
    wr_data_in <= wv;
    @(posedge clk_in);
    load <= 1'b0;
    addr_in <= REG_FLAGS;
    wr_data_in <= 8'h0f;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : prep

  task automatic run(input logic [3:0] c, input logic [7:0] iv);
    @(posedge clk_in);
    op_valid_in <= 1'b1;
    op_in <= c;
    imm_in <= iv;
    @(posedge clk_in);
    op_valid_in <= 1'b0;
    #1;
  endtask : run

  function automatic logic [7:0] expect_of(input logic [3:0] c, input logic [7:0] a, b, x, y);
    case (c)
      4'h1: return a & y;
      4'h2, 4'h3: return a & b;
      4'h4: return a | y;
      4'h5, 4'h6: return a | b;
      4'h7: return a ^ y;
      4'h8, 4'h9: return a ^ b;
      4'ha: return a ^ x;
      4'hb: return ~a;
      4'hc: return ~b;
      4'hd: return 8'h00 - a;
      default: return 8'h00 - b;
    endcase
  endfunction : expect_of

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  ////////////////////////////////////////
  // Hang guard, well past the hundred or so cycles the tests take
  initial begin
    repeat (5000) @(posedge clk_in);
    bad_count++;
    results();
  end

  initial begin
    logic acc, mem, io;
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(REG_WORK, d);
    chk("work after reset", 8'h00, d);
    // Op codes 1 to 14, with flags preset to all ones so a nonzero result must clear Z, except for the IO form (code 10), which leaves Z set
    for (int c = 1; c <= 14; c++) begin
      {w, m, v, i} = tbl[c];
      r = expect_of(c[3:0], w, m, v, i);
      acc = c inside {1, 2, 4, 5, 7, 8, 11, 13};
      mem = c inside {3, 6, 9, 12, 14};
      io = (c == 10);
      prep(w, m, v);
      run(c[3:0], i);
      chk("work", acc ? r : w, work_register_out);
      chk("strobes", {5'h0, mem, io, 1'b1}, {5'h0, mem_we_out, io_we_out, done_out});
      if (mem) chk("mem data", r, mem_wdata_out);
      if (io) chk("io data", r, io_wdata_out);
      chk("zero", {7'h0, io || r == 8'h00}, {7'h0, zero_flag_out});
      chk("kept flags", 8'h07, {5'h0, carry_flag_out, half_borrow_bit_out, signed_wrap_bit_out});
    end
    // Back to back: second op sees the first op's work value
    prep(8'hf3, 8'h00, 8'h00);
    @(posedge clk_in);
    op_valid_in <= 1'b1;
    op_in <= 4'h1;
    imm_in <= 8'h0f;
    @(posedge clk_in);
    op_in <= 4'h7;
    imm_in <= 8'h03;
    @(posedge clk_in);
    op_valid_in <= 1'b0;
    #1 chk("chained work", 8'h00, work_register_out);
    chk("chained zero", 8'h01, {7'h0, zero_flag_out});
    // Illegal code is refused and remembered
    run(4'hf, 8'h00);
    chk("illegal done", 8'h00, {7'h0, done_out});
    rd(REG_STATUS, d);
    chk("illegal status", 8'h08, d & 8'h08);
    rd(4'hf, d);
    chk("unmapped read", 8'h00, d);
    results();
  end
endmodule : logic_op_alu_test

/* File: verilog/alu_if.sv */
`timescale 1ns/1ps
// Operands in, result and destination decode out
interface alu_if;
  import logic_op_pkg::*;
  op_t        op;
  logic [7:0] acc;
  logic [7:0] imm;
  logic [7:0] mem;
  logic [7:0] io;
  logic [7:0] result;
  logic       zero;
  logic       to_acc;
  logic       to_mem;
  logic       to_io;
  logic       upd_zero;

  modport core (output op, acc, imm, mem, io,
                input  result, zero, to_acc, to_mem, to_io, upd_zero);
  modport unit (input  op, acc, imm, mem, io,
                output result, zero, to_acc, to_mem, to_io, upd_zero);
endinterface : alu_if

/* File: verilog/logic_op_alu.sv */
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module logic_op_alu
  import logic_op_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // Operation strobe from the instruction decoder
  input  wire logic              op_valid_in,
  input  wire logic [3:0]        op_in,
  input  wire logic [7:0]        imm_in,
  input  wire logic [7:0]        mem_rdata_in,
  input  wire logic [7:0]        io_rdata_in,
  // Write-back towards data memory and IO registers
  output logic                   mem_we_out,
  output logic [7:0]             mem_wdata_out,
  output logic                   io_we_out,
  output logic [7:0]             io_wdata_out,
  output logic                   done_out,
  // Core state seen by the rest of the core
  output logic [7:0]             work_register_out,
  output logic                   zero_flag_out,
  output logic                   carry_flag_out,
  output logic                   half_borrow_bit_out,
  output logic                   signed_wrap_bit_out,
  // Plain register port
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [7:0]        wr_data_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic [7:0]             rd_data_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  alu_if      unit_if ();

  op_t        op;
  logic       legal;
  logic       fire;

  logic [7:0] work_register_q;
  logic [7:0] work_register_d;
  logic [3:0] flags_q;
  logic [3:0] flags_d;
  logic [7:0] result_q;
  logic [7:0] result_d;
  logic [3:0] status_q;
  logic [3:0] status_d;
  logic [7:0] count_q;
  logic [7:0] count_d;

  logic       mem_we_q;
  logic       mem_we_d;
  logic [7:0] mem_wdata_q;
  logic [7:0] mem_wdata_d;
  logic       io_we_q;
  logic       io_we_d;
  logic [7:0] io_wdata_q;
  logic [7:0] io_wdata_d;
  logic       done_q;
  logic       done_d;

  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;

  logic       wr_work;
  logic       wr_flags;
  logic       wr_status;

  ////////////////////////////////////////////////////////////////////////////
  // Opcode check; codes past the last operation count as illegal
  always_comb begin
    legal = (op_in <= 4'(OP_NEG_MEM));
    op    = legal ? op_t'(op_in) : OP_NOP;
    fire  = op_valid_in && legal && (op != OP_NOP);
  end

  // Feed the combinational logic unit
  assign unit_if.op  = op;
  assign unit_if.acc = work_register_q;
  assign unit_if.imm = imm_in;
  assign unit_if.mem = mem_rdata_in;
  assign unit_if.io  = io_rdata_in;

  logic_unit u_unit (
    .port (unit_if.unit)
  );

  // Register port write decode
  assign wr_work   = wr_in && (addr_in == REG_WORK);
  assign wr_flags  = wr_in && (addr_in == REG_FLAGS);
  assign wr_status = wr_in && (addr_in == REG_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Work register and flags
  // An operation in the same cycle as a software write wins, so the
  // instruction stream never loses a result to a debug poke.
  always_comb begin
    work_register_d = work_register_q;
    flags_d         = flags_q;
    if (wr_work) begin
      work_register_d = wr_data_in;
    end
    if (wr_flags) begin
      flags_d = wr_data_in[3:0];
    end
    if (fire && unit_if.to_acc) begin
      work_register_d = unit_if.result;
    end
    // Carry, half-borrow and signed-wrap bits change only on a flags write, never from an operation
    if (fire && unit_if.upd_zero) begin
      flags_d[FLAG_ZERO_BIT] = unit_if.zero;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      work_register_q <= WORK_RST;
      flags_q         <= FLAGS_RST;
    end else begin
      work_register_q <= work_register_d;
      flags_q         <= flags_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory and IO write-back, one-cycle pulses after the operation
  always_comb begin
    mem_we_d    = fire && unit_if.to_mem;
    io_we_d     = fire && unit_if.to_io;
    done_d      = fire;
    mem_wdata_d = mem_wdata_q;
    io_wdata_d  = io_wdata_q;
    if (mem_we_d) begin
      mem_wdata_d = unit_if.result;
    end
    if (io_we_d) begin
      io_wdata_d = unit_if.result;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mem_we_q    <= 1'b0;
      mem_wdata_q <= ZERO_BYTE;
      io_we_q     <= 1'b0;
      io_wdata_q  <= ZERO_BYTE;
      done_q      <= 1'b0;
    end else begin
      mem_we_q    <= mem_we_d;
      mem_wdata_q <= mem_wdata_d;
      io_we_q     <= io_we_d;
      io_wdata_q  <= io_wdata_d;
      done_q      <= done_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Last result, destination status and operation count
  // Illegal-code bit is sticky; a new illegal code beats a clear.
  always_comb begin
    result_d = result_q;
    status_d = status_q;
    count_d  = count_q;
    if (wr_status && wr_data_in[STAT_ILLEGAL_BIT]) begin
      status_d[STAT_ILLEGAL_BIT] = 1'b0;
    end
    if (op_valid_in && !legal) begin
      status_d[STAT_ILLEGAL_BIT] = 1'b1;
    end
    if (fire) begin
      result_d                = unit_if.result;
      status_d[STAT_ACC_BIT]  = unit_if.to_acc;
      status_d[STAT_MEM_BIT]  = unit_if.to_mem;
      status_d[STAT_IO_BIT]   = unit_if.to_io;
      count_d                 = count_q + ONE_BYTE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      result_q <= RESULT_RST;
      status_q <= STATUS_RST;
      count_q  <= COUNT_RST;
    end else begin
      result_q <= result_d;
      status_q <= status_d;
      count_q  <= count_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read, data valid only in the cycle after the strobe
  always_comb begin
    rd_data_d = ZERO_BYTE;
    if (rd_in) begin
      unique case (addr_in)
        REG_WORK:   rd_data_d = work_register_q;
        REG_FLAGS:  rd_data_d = {4'h0, flags_q};
        REG_RESULT: rd_data_d = result_q;
        REG_STATUS: rd_data_d = {4'h0, status_q};
        REG_COUNT:  rd_data_d = count_q;
        default:    rd_data_d = ZERO_BYTE;   // Unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_data_q <= ZERO_BYTE;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops
  assign mem_we_out          = mem_we_q;
  assign mem_wdata_out       = mem_wdata_q;
  assign io_we_out           = io_we_q;
  assign io_wdata_out        = io_wdata_q;
  assign done_out            = done_q;
  assign work_register_out   = work_register_q;
  assign zero_flag_out       = flags_q[FLAG_ZERO_BIT];
  assign carry_flag_out      = flags_q[FLAG_CARRY_BIT];
  assign half_borrow_bit_out = flags_q[FLAG_HALF_BIT];
  assign signed_wrap_bit_out = flags_q[FLAG_WRAP_BIT];
  assign rd_data_out         = rd_data_q;

endmodule : logic_op_alu

/* File: verilog/logic_op_pkg.sv */
package logic_op_pkg;

  // Widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;

  // Register map of the plain register port
  localparam logic [3:0] REG_WORK   = 4'h0;
  localparam logic [3:0] REG_FLAGS  = 4'h1;
  localparam logic [3:0] REG_RESULT = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_COUNT  = 4'h4;

  // Flag register field positions
  localparam int FLAG_ZERO_BIT  = 0;
  localparam int FLAG_CARRY_BIT = 1;
  localparam int FLAG_HALF_BIT  = 2;
  localparam int FLAG_WRAP_BIT  = 3;

  // Status register field positions
  localparam int STAT_ACC_BIT     = 0;
  localparam int STAT_MEM_BIT     = 1;
  localparam int STAT_IO_BIT      = 2;
  localparam int STAT_ILLEGAL_BIT = 3;

  // Reset values
  localparam logic [7:0] WORK_RST   = 8'h00;
  localparam logic [3:0] FLAGS_RST  = 4'h0;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [3:0] STATUS_RST = 4'h0;
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [7:0] ONE_BYTE   = 8'h01;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;

  // Operations handled by this slice
  typedef enum logic [3:0] {
    OP_NOP,
    OP_AND_A_IMM,
    OP_AND_A_MEM,
    OP_AND_MEM_A,
    OP_OR_A_IMM,
    OP_OR_A_MEM,
    OP_OR_MEM_A,
    OP_XOR_A_IMM,
    OP_XOR_A_MEM,
    OP_XOR_MEM_A,
    OP_XOR_IO_A,
    OP_NOT_A,
    OP_NOT_MEM,
    OP_NEG_A,
    OP_NEG_MEM
  } op_t;

  typedef enum logic [1:0] {SRC_NONE, SRC_IMM, SRC_MEM, SRC_IO} src_t;
  typedef enum logic [2:0] {FN_PASS, FN_AND, FN_OR, FN_XOR, FN_NOT, FN_NEG} fn_t;

  // Second operand source
  function automatic src_t op_source(input op_t op);
    unique case (op)
      OP_AND_A_IMM, OP_OR_A_IMM, OP_XOR_A_IMM:                  op_source = SRC_IMM;
      OP_AND_A_MEM, OP_AND_MEM_A, OP_OR_A_MEM, OP_OR_MEM_A,
      OP_XOR_A_MEM, OP_XOR_MEM_A, OP_NOT_MEM, OP_NEG_MEM:       op_source = SRC_MEM;
      OP_XOR_IO_A:                                              op_source = SRC_IO;
      default:                                                  op_source = SRC_NONE;
    endcase
  endfunction : op_source

  // Logic function
  function automatic fn_t op_fn(input op_t op);
    unique case (op)
      OP_AND_A_IMM, OP_AND_A_MEM, OP_AND_MEM_A:              op_fn = FN_AND;
      OP_OR_A_IMM, OP_OR_A_MEM, OP_OR_MEM_A:                 op_fn = FN_OR;
      OP_XOR_A_IMM, OP_XOR_A_MEM, OP_XOR_MEM_A, OP_XOR_IO_A: op_fn = FN_XOR;
      OP_NOT_A, OP_NOT_MEM:                                  op_fn = FN_NOT;
      OP_NEG_A, OP_NEG_MEM:                                  op_fn = FN_NEG;
      default:                                               op_fn = FN_PASS;
    endcase
  endfunction : op_fn

  // Destination decode
  function automatic logic op_to_acc(input op_t op);
    op_to_acc = (op == OP_AND_A_IMM) || (op == OP_AND_A_MEM) || (op == OP_OR_A_IMM) ||
                (op == OP_OR_A_MEM) || (op == OP_XOR_A_IMM) || (op == OP_XOR_A_MEM) ||
                (op == OP_NOT_A) || (op == OP_NEG_A);
  endfunction : op_to_acc

  function automatic logic op_to_mem(input op_t op);
    op_to_mem = (op == OP_AND_MEM_A) || (op == OP_OR_MEM_A) || (op == OP_XOR_MEM_A) ||
                (op == OP_NOT_MEM) || (op == OP_NEG_MEM);
  endfunction : op_to_mem

  function automatic logic op_to_io(input op_t op);
    op_to_io = (op == OP_XOR_IO_A);
  endfunction : op_to_io

  // Every form except the IO one and the no-op touches the zero flag
  function automatic logic op_sets_zero(input op_t op);
    op_sets_zero = op_to_acc(op) || op_to_mem(op);
  endfunction : op_sets_zero

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == ZERO_BYTE);
  endfunction : is_zero

endpackage : logic_op_pkg

/* File: verilog/logic_unit.sv */
`timescale 1ns/1ps
module logic_unit
  import logic_op_pkg::*;
(
  alu_if.unit port
);

  src_t       src;
  fn_t        fn;
  logic [7:0] operand;
  logic [7:0] value;

  ////////////////////////////////////////////////////////////////////////////
  // Operand select and bitwise function
  always_comb begin
    src     = op_source(port.op);
    fn      = op_fn(port.op);
    operand = ZERO_BYTE;
    unique case (src)
      SRC_IMM:  operand = port.imm;
      SRC_MEM:  operand = port.mem;
      SRC_IO:   operand = port.io;
      SRC_NONE: operand = ZERO_BYTE;
    endcase
    // Complement forms work on the memory byte when it is the source
    unique case (fn)
      FN_AND:  value = port.acc & operand;
      FN_OR:   value = port.acc | operand;
      FN_XOR:  value = port.acc ^ operand;
      FN_NOT:  value = (src == SRC_MEM) ? ~operand : ~port.acc;
      FN_NEG:  value = (src == SRC_MEM) ? (~operand) + ONE_BYTE
                                        : (~port.acc) + ONE_BYTE;
      FN_PASS: value = port.acc;
      default: value = port.acc;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result and destination decode
  assign port.result   = value;
  assign port.zero     = is_zero(value);
  assign port.to_acc   = op_to_acc(port.op);
  assign port.to_mem   = op_to_mem(port.op);
  assign port.to_io    = op_to_io(port.op);
  assign port.upd_zero = op_sets_zero(port.op);

endmodule : logic_unit
